/* hw/apd_pkg.sv */
// pwrdn_pkg: constants and types shared by the power-down unit and its counter.
// assumes a 100 MHz core clock; all figures below are used by name only.
package pwrdn_pkg;

  // ****************************************************************
  // idle counter
  // ****************************************************************
  localparam int                CTR_W     = 4;
  localparam logic [CTR_W-1:0]  IDLE_LAST = 4'hF;
  localparam logic [CTR_W-1:0]  CTR_ZERO  = 4'h0;

  // ****************************************************************
  // power-mode registers
  // ****************************************************************
  localparam int             PM_W              = 8;
  localparam logic [PM_W-1:0] PM_RESET         = 8'h00;
  // only bits 1, 3, 4 and 5 exist in register 0; the rest read zero
  localparam logic [PM_W-1:0] PM0_WR_MASK      = 8'h3A;
  localparam int             PM0_AUTO_EN       = 1;
  localparam int             PM0_FAST_OFF      = 3;
  localparam int             PM0_AND_CLK_OFF   = 4;
  localparam int             PM0_MCELL_CLK_OFF = 5;
  localparam logic           PM_SEL_REG0       = 1'b0;

  // ****************************************************************
  // memory selects: flash, eeprom, sram, io control decode
  // ****************************************************************
  localparam int              MEM_N    = 4;
  localparam logic [MEM_N-1:0] MEM_NONE = 4'h0;
  localparam logic [MEM_N-1:0] MEM_ALL  = 4'hF;

  // ****************************************************************
  // port pin function while powered down
  // ****************************************************************
  localparam logic [1:0] PIN_HOLD     = 2'h0;
  localparam logic [1:0] PIN_ADDR_OUT = 2'h1;
  localparam logic [1:0] PIN_TRI      = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         ARRAY_IDLE_NS  = 70;
  localparam int         ARRAY_IDLE_CYC = (ARRAY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ARRAY_IDLE_CNT = 4'(ARRAY_IDLE_CYC);
  localparam logic [3:0] WAIT_ZERO      = 4'h0;

  typedef enum logic {ST_RUN, ST_DOWN} pd_state_e;

endpackage

/* hw/apd_ctr_if.sv */
// idle_ctr_if: link between the power-down control and its idle counter.
// assumes both ends sit on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface idle_ctr_if;
  import pwrdn_pkg::*;
  logic             tick;
  logic             strobe_pulse;
  logic             count_en;
  logic [CTR_W-1:0] count;
  logic             expired;

  modport ctl (output tick, output strobe_pulse, output count_en,
               input count, input expired);
  modport ctr (input tick, input strobe_pulse, input count_en,
               output count, output expired);
endinterface
`default_nettype wire

/* hw/apd_idle_counter.sv */
// idle_counter: four-bit count of input-clock periods without strobe.
// assumes tick and strobe_pulse are one-cycle pulses on core_clk.
`timescale 1ns/1ps
`default_nettype none
module idle_counter
  import pwrdn_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // counter link
  idle_ctr_if.ctr   cif
);

  logic [CTR_W-1:0] count_r;

  // a strobe in the same cycle as a tick wins: the idle interval restarts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_r <= CTR_ZERO;
    end else if (!cif.count_en || cif.strobe_pulse) begin
      count_r <= CTR_ZERO;
    end else if (cif.tick && count_r != IDLE_LAST) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign cif.count   = count_r;
  assign cif.expired = (count_r == IDLE_LAST);

endmodule
`default_nettype wire

/* hw/auto_power_down_unit.sv */
// auto_power_down_unit: strobe idle watch, power-down state, bus blocking,
// memory deselect, port pin hold and the two power-mode registers.
// assumes every pin input is synchronous to core_clk; srst is power-up only.
`timescale 1ns/1ps
`default_nettype none
module auto_power_down_unit
  import pwrdn_pkg::*;
#(
  parameter int         AW            = 16,
  parameter int         DW            = 8,
  parameter int         CW            = 8,
  parameter int         PINS          = 8,
  parameter logic [3:0] WAKE_WAIT_CYC = 4'h2
) (
  // clock and power-up reset
  input  wire logic                core_clk,
  input  wire logic                srst,
  // device pins
  input  wire logic                addr_strobe_in,
  input  wire logic                logic_clock_in,
  input  wire logic                cs_n_in,
  input  wire logic                reset_n_in,
  // MCU bus
  input  wire logic [AW-1:0]       mcu_addr_in,
  input  wire logic [DW-1:0]       mcu_data_in,
  input  wire logic [CW-1:0]       mcu_ctrl_in,
  // power-mode register access
  input  wire logic                pm_wr_en,
  input  wire logic                pm_wr_sel,
  input  wire logic [PM_W-1:0]     pm_wr_data,
  output logic      [PM_W-1:0]     power_mode_reg0,
  output logic      [PM_W-1:0]     power_mode_reg2,
  // logic array side
  output logic      [AW-1:0]       array_addr,
  output logic      [DW-1:0]       array_data,
  output logic      [CW-1:0]       array_ctrl,
  output logic                     and_array_tick,
  output logic                     mcell_tick,
  output logic                     fast_mode_on,
  output logic                     array_standby,
  // memory side
  output logic      [MEM_N-1:0]    mem_enable,
  output logic                     mem_wait,
  output logic                     mem_standby,
  // port pins
  input  wire logic [2*PINS-1:0]   pin_mode,
  input  wire logic [PINS-1:0]     pin_out_core,
  input  wire logic [PINS-1:0]     pin_oe_core,
  output logic      [PINS-1:0]     pin_out,
  output logic      [PINS-1:0]     pin_oe,
  // status
  output logic                     power_down_signal
);

  // ****************************************************************
  // pin edge detection
  // ****************************************************************
  logic strobe_prev_r;
  logic clk_prev_r;
  logic cs_prev_r;
  logic rst_prev_r;
  logic strobe_pulse;
  logic clk_rise;
  logic cs_fall;
  logic rst_rise;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      strobe_prev_r <= 1'b0;
      clk_prev_r    <= 1'b0;
      cs_prev_r     <= 1'b0;
      rst_prev_r    <= 1'b1;
    end else begin
      strobe_prev_r <= addr_strobe_in;
      clk_prev_r    <= logic_clock_in;
      cs_prev_r     <= cs_n_in;
      rst_prev_r    <= reset_n_in;
    end
  end

  assign strobe_pulse = addr_strobe_in & ~strobe_prev_r;
  assign clk_rise     = logic_clock_in & ~clk_prev_r;
  assign cs_fall      = cs_prev_r & ~cs_n_in;
  assign rst_rise     = reset_n_in & ~rst_prev_r;

  // ****************************************************************
  // power-mode registers
  // ****************************************************************
  logic [PM_W-1:0] pm0_r;
  logic [PM_W-1:0] pm2_r;
  logic            auto_en;

  // the device reset pin is deliberately not looked at here
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pm0_r <= PM_RESET;
      pm2_r <= PM_RESET;
    end else if (pm_wr_en) begin
      if (pm_wr_sel == PM_SEL_REG0) begin
        pm0_r <= pm_wr_data & PM0_WR_MASK;
      end else begin
        pm2_r <= pm_wr_data;
      end
    end
  end

  assign power_mode_reg0 = pm0_r;
  assign power_mode_reg2 = pm2_r;
  assign auto_en         = pm0_r[PM0_AUTO_EN];
  assign fast_mode_on    = ~pm0_r[PM0_FAST_OFF];

  // ****************************************************************
  // idle counter and power-down state
  // ****************************************************************
  idle_ctr_if cif ();
  pd_state_e  state_r;
  logic       pd;

  idle_counter u_idle (
    .core_clk (core_clk),
    .srst     (srst),
    .cif      (cif.ctr)
  );

  // the counter sees the raw input clock edge, whatever the blocking bits say
  assign cif.tick         = clk_rise;
  assign cif.strobe_pulse = strobe_pulse;
  assign cif.count_en     = auto_en && (state_r == ST_RUN);

  // enabling the unit is all it takes; there is no second entry switch
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= ST_RUN;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (auto_en && cif.expired) begin
            state_r <= ST_DOWN;
          end
        end
        ST_DOWN: begin
          if (strobe_pulse) begin
            state_r <= ST_RUN;
          end else if (cs_fall || rst_rise) begin
            state_r <= ST_RUN;
          end else if (!auto_en) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  assign pd                = (state_r == ST_DOWN);
  assign power_down_signal = pd;

  // ****************************************************************
  // array side: bus blocking, control blocking, clock gating
  // ****************************************************************
  logic [CW-1:0] ctrl_pass;

  genvar gi;
  generate
    for (gi = 0; gi < CW; gi++) begin : g_ctrl_block
      assign ctrl_pass[gi] = mcu_ctrl_in[gi] & ~pm2_r[gi];
    end
  endgenerate

  // arrays keep the last address and data while powered down; chip select does not
  // take part, so deselecting the memories never starves the arrays
  always_ff @(posedge core_clk) begin
    if (srst) begin
      array_addr <= '0;
      array_data <= '0;
    end else if (!pd) begin
      array_addr <= mcu_addr_in;
      array_data <= mcu_data_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      array_ctrl <= '0;
    end else begin
      array_ctrl <= ctrl_pass;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      and_array_tick <= 1'b0;
      mcell_tick     <= 1'b0;
    end else begin
      and_array_tick <= clk_rise & ~pm0_r[PM0_AND_CLK_OFF];
      mcell_tick     <= clk_rise & ~pm0_r[PM0_MCELL_CLK_OFF];
    end
  end

  // ****************************************************************
  // array standby
  // ****************************************************************
  logic       array_change;
  logic [3:0] arr_idle_r;

  assign array_change = (clk_rise && !pm0_r[PM0_AND_CLK_OFF])
                     || (ctrl_pass != array_ctrl)
                     || (!pd && (mcu_addr_in != array_addr))
                     || (!pd && (mcu_data_in != array_data));

  // with fast mode on the arrays never idle down, trading power for speed
  always_ff @(posedge core_clk) begin
    if (srst) begin
      arr_idle_r <= WAIT_ZERO;
    end else if (array_change) begin
      arr_idle_r <= WAIT_ZERO;
    end else if (arr_idle_r != ARRAY_IDLE_CNT) begin
      arr_idle_r <= arr_idle_r + 1'b1;
    end
  end

  assign array_standby = !fast_mode_on && (arr_idle_r == ARRAY_IDLE_CNT);

  // ****************************************************************
  // memory side
  // ****************************************************************
  logic       bus_change;
  logic [3:0] wait_cnt_r;

  assign mem_enable = (!cs_n_in && !pd) ? MEM_ALL : MEM_NONE;
  assign bus_change = (mcu_addr_in != array_addr) || (mcu_data_in != array_data);

  // a memory wakes for one cycle per visible bus change, then idles again
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_standby <= 1'b1;
    end else begin
      mem_standby <= !(bus_change && !pd && !cs_n_in);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_cnt_r <= WAIT_ZERO;
    end else if (cs_fall) begin
      wait_cnt_r <= WAKE_WAIT_CYC;
    end else if (wait_cnt_r != WAIT_ZERO) begin
      wait_cnt_r <= wait_cnt_r - 1'b1;
    end
  end

  assign mem_wait = (wait_cnt_r != WAIT_ZERO);

  // ****************************************************************
  // port pins
  // ****************************************************************
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      logic [1:0] mode;
      assign mode = pin_mode[2*gi +: 2];

      // address-out pins are undefined when powered down; low is chosen here
      always_ff @(posedge core_clk) begin
        if (srst) begin
          pin_out[gi] <= 1'b0;
          pin_oe[gi]  <= 1'b0;
        end else if (!pd) begin
          pin_out[gi] <= pin_out_core[gi];
          pin_oe[gi]  <= pin_oe_core[gi];
        end else if (mode == PIN_ADDR_OUT) begin
          pin_out[gi] <= 1'b0;
        end else if (mode == PIN_TRI) begin
          pin_oe[gi]  <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_idle_done;
    (state_r == ST_RUN) && auto_en && cif.expired;
  endsequence

  sequence s_enter_pd;
    ##1 (pd && power_down_signal && mem_enable == MEM_NONE);
  endsequence

  a_idle_entry: assert property (s_idle_done |-> s_enter_pd)
    else $error("power-down not entered after idle count");

  a_count_step: assert property ((state_r == ST_RUN) && auto_en && clk_rise
      && !strobe_pulse && cif.count != IDLE_LAST
      |=> cif.count == $past(cif.count) + 1'b1)
    else $error("idle counter did not step on input clock");

  a_count_clear: assert property (strobe_pulse |=> cif.count == CTR_ZERO)
    else $error("strobe did not clear idle counter");

  a_no_entry_off: assert property (!auto_en && !pd |=> !pd)
    else $error("power-down entered while disabled");

  a_strobe_wake: assert property (pd && strobe_pulse |=> !pd && !power_down_signal)
    else $error("strobe did not wake");

  a_pin_wake: assert property (pd && (cs_fall || rst_rise) |=> !pd)
    else $error("chip select or reset did not wake");

  a_bus_block: assert property (pd ##1 pd |-> $stable(array_addr) && $stable(array_data))
    else $error("bus reached arrays while powered down");

  a_mem_desel: assert property (pd || cs_n_in |-> mem_enable == MEM_NONE)
    else $error("memory selected while down or deselected");

  a_wake_wait: assert property (cs_fall |=> mem_wait [*2] ##1 !mem_wait)
    else $error("chip select wait length wrong");

  a_and_gate: assert property (pm0_r[PM0_AND_CLK_OFF] |=> !and_array_tick)
    else $error("clock reached AND array while cut off");

  a_pm_keep: assert property (!pm_wr_en ##1 rst_rise |-> $stable(power_mode_reg0))
    else $error("device reset changed power-mode register");

  a_fast_awake: assert property (fast_mode_on |-> !array_standby)
    else $error("array standby while fast mode on");

endmodule
`default_nettype wire

/* tb/apd_mcu_model.sv */
// mcu_host_model: host MCU side, makes the address strobe, the input clock and the address.
// assumes commands change on the falling edge by non-blocking assignment.
`timescale 1ns/1ps
`default_nettype none
module mcu_host_model (
  // clock
  input  wire logic        core_clk,
  // commands from the bench
  input  wire logic        clk_run,
  input  wire logic        strobe_go,
  // pins toward the device
  output logic             strobe_o,
  output logic             lclk_o,
  output logic [15:0]      addr_o
);
  // ****************************************************************
  // pins
  // ****************************************************************
  initial begin
    strobe_o = 1'b0;
    lclk_o   = 1'b0;
    addr_o   = 16'h1000;
  end
  // clock stands low while stopped, as a sleeping host would leave it
  always @(negedge core_clk) begin
    lclk_o   <= clk_run ? ~lclk_o : 1'b0;
    strobe_o <= strobe_go & ~strobe_o;
    if (strobe_go & ~strobe_o) begin
      addr_o <= addr_o + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// tb_top: self-checking bench of the auto power-down unit.
// assumes the unit's default parameters and a 100 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  import pwrdn_pkg::*;
  logic        core_clk = 1'b0, srst = 1'b1, cs_n_in = 1'b0, reset_n_in = 1'b1;
  logic        clk_run = 1'b0, strobe_go = 1'b0, pm_wr_en = 1'b0, pm_wr_sel = 1'b0;
  logic [7:0]  pm_wr_data = 8'h00, mcu_data_in = 8'h00, mcu_ctrl_in = 8'h00;
  logic [7:0]  pin_out_core = 8'hA5, pin_oe_core = 8'hFF;
  logic [15:0] pin_mode = 16'hAA50;
  logic        strobe, lclk, and_tick, mc_tick, fast_on, arr_sb, mem_wait, mem_sb, pds;
  logic [15:0] mcu_addr, array_addr;
  logic [7:0]  reg0, reg2, array_data, array_ctrl, pin_out, pin_oe, d;
  logic [3:0]  mem_en;
  int          err_total = 0, comparisons = 0, n, t;

  always #5 core_clk = ~core_clk;

  mcu_host_model i_mcu_host_model (.core_clk(core_clk), .clk_run(clk_run),
    .strobe_go(strobe_go), .strobe_o(strobe), .lclk_o(lclk), .addr_o(mcu_addr));

  auto_power_down_unit i_auto_power_down_unit (.core_clk(core_clk), .srst(srst),
    .addr_strobe_in(strobe), .logic_clock_in(lclk), .cs_n_in(cs_n_in),
    .reset_n_in(reset_n_in), .mcu_addr_in(mcu_addr), .mcu_data_in(mcu_data_in),
    .mcu_ctrl_in(mcu_ctrl_in), .pm_wr_en(pm_wr_en), .pm_wr_sel(pm_wr_sel),
    .pm_wr_data(pm_wr_data), .power_mode_reg0(reg0), .power_mode_reg2(reg2),
    .array_addr(array_addr), .array_data(array_data), .array_ctrl(array_ctrl),
    .and_array_tick(and_tick), .mcell_tick(mc_tick), .fast_mode_on(fast_on),
    .array_standby(arr_sb), .mem_enable(mem_en), .mem_wait(mem_wait),
    .mem_standby(mem_sb), .pin_mode(pin_mode), .pin_out_core(pin_out_core),
    .pin_oe_core(pin_oe_core), .pin_out(pin_out), .pin_oe(pin_oe),
    .power_down_signal(pds));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic cyc(input int c);
    repeat (c) @(negedge core_clk);
  endtask
  task automatic wr(input logic sel, input logic [7:0] v);
    pm_wr_en <= 1'b1; pm_wr_sel <= sel; pm_wr_data <= v;
    cyc(1);
    pm_wr_en <= 1'b0;
    cyc(1);
  endtask
  task automatic wait_pds(input logic v, input int lim);
    n = 0;
    while (pds !== v && n < lim) begin
      cyc(1); n++;
    end
  endtask
  task automatic pulse_strobe();
    strobe_go <= 1'b1;
    cyc(1);
    strobe_go <= 1'b0;
    cyc(2);
  endtask
  // clock runs until power-down shows; 15 rises need 30 cycles
  task automatic go_down();
    clk_run <= 1'b1;
    wait_pds(1'b1, 40);
    clk_run <= 1'b0;
    cyc(2);
    `CHK(pds, 1'b1)
  endtask
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_regs();
    `CHK(reg0, 8'h00)
    `CHK(reg2, 8'h00)
    `CHK(fast_on, 1'b1)
    `CHK(pds, 1'b0)
    `CHK(mem_en, MEM_ALL)
    wr(0, 8'hFF);
    `CHK(reg0, PM0_WR_MASK)
    wr(0, 8'h08);
    `CHK(fast_on, 1'b0)
    cyc(10);
    `CHK(arr_sb, 1'b1)
    wr(0, 8'h00);
    clk_run <= 1'b1;
    cyc(40);
    `CHK(pds, 1'b0)
    clk_run <= 1'b0;
    fin("reset_regs");
  endtask

  task automatic t_entry();
    wr(0, 8'h02);
    clk_run <= 1'b1;
    cyc(27);
    `CHK(pds, 1'b0)
    wait_pds(1'b1, 10);
    `CHK(n, 4)
    d = array_data;
    mcu_data_in <= ~d;
    t = 0;
    repeat (12) begin
      cyc(1); t += int'(and_tick) + int'(mc_tick);
    end
    `CHK(t, 12)
    `CHK(array_data, d)
    `CHK(mem_en, MEM_NONE)
    `CHK(pin_oe[7:4], 4'h0)
    `CHK(pin_out[1:0], 2'b01)
    `CHK(pin_out[3:2], 2'b00)
    `CHK(pin_oe[1:0], 2'b11)
    clk_run <= 1'b0;
    pulse_strobe();
    wait_pds(1'b0, 4);
    `CHK(pds, 1'b0)
    `CHK(array_addr, mcu_addr)
    `CHK(array_data, ~d)
    fin("entry");
  endtask

  task automatic t_restart();
    clk_run <= 1'b1;
    repeat (4) begin
      cyc(20);
      pulse_strobe();
      `CHK(pds, 1'b0)
    end
    clk_run <= 1'b0;
    fin("restart");
  endtask

  task automatic t_wakes();
    go_down();
    cs_n_in <= 1'b1;
    cyc(2);
    `CHK(mem_en, MEM_NONE)
    cs_n_in <= 1'b0;
    t = 0;
    repeat (5) begin
      cyc(1); t += int'(mem_wait);
    end
    `CHK(t, int'(4'h2))
    `CHK(pds, 1'b0)
    go_down();
    reset_n_in <= 1'b0;
    cyc(2);
    reset_n_in <= 1'b1;
    wait_pds(1'b0, 4);
    `CHK(pds, 1'b0)
    `CHK(reg0, 8'h02)
    fin("wakes");
  endtask

  task automatic t_blocking();
    wr(0, 8'h32);
    `CHK(reg0, 8'h32)
    clk_run <= 1'b1;
    t = 0;
    repeat (40) begin
      cyc(1); t += int'(and_tick) + int'(mc_tick);
    end
    `CHK(t, 0)
    `CHK(pds, 1'b1)
    clk_run <= 1'b0;
    pulse_strobe();
    wr(1, 8'h0F);
    `CHK(reg2, 8'h0F)
    mcu_ctrl_in <= 8'hFF;
    cyc(2);
    `CHK(array_ctrl, 8'hF0)
    cs_n_in <= 1'b1;
    mcu_data_in <= 8'h3C;
    cyc(2);
    `CHK(array_data, 8'h3C)
    `CHK(mem_en, MEM_NONE)
    cs_n_in <= 1'b0;
    cyc(3);
    mcu_data_in <= 8'hC3;
    t = 0;
    repeat (4) begin
      cyc(1); t += int'(!mem_sb);
    end
    `CHK(t, 1)
    fin("blocking");
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    cyc(16);
    srst <= 1'b0;
    cyc(1);
    t_reset_regs();
    t_entry();
    t_restart();
    t_wakes();
    t_blocking();
    test_done();
  end

  // all scenarios fit in well under 2000 cycles
  initial begin
    #50000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
